// file: rcso_ctrl_model.sv
// Bus controller model on the talker side: addresses and accepts bytes.
// Assumes the bench sets talk_en and slow; bytes land in queue got.
`default_nettype none
module rcso_ctrl_model (
  input wire logic clk,
  input wire logic talk_en,
  input wire logic slow,
  output logic talk_addressed,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got[$];
  initial begin
    talk_addressed = 1'b0;
    tx_ready = 1'b0;
  end
  // Take bytes by count, LF is plain data here; stall at random when slow
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back({tx_eoi, tx_data});
    end
    #1;
    talk_addressed = talk_en;
    tx_ready = !slow || ($urandom % 3 == 0);
  end
endmodule // rcso_ctrl_model
`default_nettype wire

// file: rcso_fifo.sv
// Byte FIFO for the talker path, valid and ready on both sides.
// Assumes a single clock and active-low asynchronous reset.
`default_nettype none
module rcso_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;

  // Handshakes and pointer advance
  always_comb begin
    in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
  end

  // Pointer registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule // rcso_fifo
`default_nettype wire

// file: rcso_pkg.sv
// Package for the remote command and state output block.
// Assumes one 125 MHz clock and a byte-wide listener and talker path.
`default_nettype none
package rcso_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FULL_DUMP_LEN = 90;
  localparam int unsigned QUICK_CW_LEN = 8;
  localparam int unsigned MODE_FLAGS_LEN = 8;
  localparam int unsigned STATUS_LEN = 3;
  localparam int unsigned NUM_REPLY_LEN = 14;
  localparam int unsigned NUM_FIELD_MAX = 14;
  localparam int unsigned MIN_ALT_SWEEP_MS = 1000;
  localparam logic [7:0] PARITY_MASK = 8'h7F;
  localparam logic [7:0] CHR_SPACE = 8'h20;
  localparam logic [7:0] CHR_PLUS = 8'h2B;
  localparam logic [7:0] CHR_MINUS = 8'h2D;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_LF = 8'h0A;
  localparam logic [7:0] CHR_SEMI = 8'h3B;
  localparam logic [7:0] CHR_COMMA = 8'h2C;
  localparam logic [7:0] CHR_LC_A = 8'h61;
  localparam logic [7:0] CHR_LC_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] CHR_DIG_9 = 8'h39;
  localparam logic [7:0] CHR_DOT = 8'h2E;
  localparam logic [7:0] CHR_E = 8'h45;
  // Preset values
  localparam logic [15:0] STEP_PCT = 16'h000A;
  localparam logic [7:0] PWR_STEP_DB = 8'h01;
  localparam logic [7:0] XTAL_MHZ = 8'h32;
  localparam logic [7:0] DISP_MULT_ONE = 8'h01;
  // Output message kinds
  typedef enum logic [2:0] {
    RCSO_MSG_FULL = 3'h0,
    RCSO_MSG_QCW = 3'h1,
    RCSO_MSG_MODE = 3'h2,
    RCSO_MSG_NUM = 3'h3,
    RCSO_MSG_STAT = 3'h4
  } rcso_msg_e;
  typedef enum logic [2:0] {
    RCSO_IDLE = 3'b001,
    RCSO_LOAD = 3'b010,
    RCSO_SEND = 3'b100
  } rcso_state_e;
endpackage : rcso_pkg
`default_nettype wire

// file: rcso_top.sv
// Remote command front end and output message serialiser.
// Assumes bus handshake is outside; bytes arrive on the instrument clock.
`default_nettype none
module rcso_top #(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned STATE_BYTES = rcso_pkg::FULL_DUMP_LEN
) (
  input wire logic clk,
  input wire logic rstn,
  // Listener side: one byte per cycle when rx_valid
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic cmd_valid,
  output logic [7:0] cmd_char,
  output logic cmd_is_term,
  output logic cmd_fund_units,
  output logic field_overflow,
  // Decoded requests from the code table
  input wire logic full_state_dump_cmd,
  input wire logic quick_cw_dump_cmd,
  input wire logic mode_flags_dump_cmd,
  input wire logic value_query_cmd,
  input wire logic active_value_query_cmd,
  input wire logic status_read_cmd,
  input wire logic preset_cmd,
  input wire logic clear_status_cmd,
  input wire logic serial_poll,
  input wire logic device_clear,
  // State sources
  input wire logic [STATE_BYTES*8-1:0] state_image,
  input wire logic [63:0] quick_cw_image,
  input wire logic [63:0] mode_flags_image,
  input wire logic [rcso_pkg::NUM_REPLY_LEN*8-1:0] value_text,
  input wire logic [rcso_pkg::NUM_REPLY_LEN*8-1:0] active_text,
  input wire logic [7:0] status_set1,
  input wire logic [7:0] status_set2,
  input wire logic [7:0] status_set3,
  input wire logic alt_sweep_two_power,
  input wire logic [15:0] sweep_time_ms,
  output logic [15:0] first_sweep_time_ms,
  // Status and preset outputs
  output logic [7:0] status1,
  output logic [7:0] status2,
  output logic [7:0] status3,
  output logic preset_pulse,
  output logic blanking_on,
  output logic rf_filter_on,
  output logic [15:0] step_pct,
  output logic [7:0] pwr_step_db,
  output logic [7:0] slope_db,
  output logic [7:0] xtal_mhz,
  output logic xtal_on,
  output logic [4:0] marker_on,
  output logic [7:0] disp_mult,
  output logic [15:0] disp_offset,
  output logic [15:0] vernier,
  // Talker side
  input wire logic talk_addressed,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_eoi,
  output logic busy
);
  localparam int unsigned NUM_BITS = rcso_pkg::NUM_REPLY_LEN * 8;

  // Receive normaliser state
  logic [7:0] ch;
  logic is_digit, is_sign, is_term;
  logic in_num, next_in_num, seen_nz, next_seen_nz;
  logic [4:0] num_len, next_num_len;
  logic next_cmd_valid, next_cmd_is_term, next_cmd_fund, next_ovf;
  logic [7:0] next_cmd_char;
  logic prev_alpha, next_prev_alpha;

  // Clear parity, fold case, classify
  always_comb begin
    ch = rx_data & rcso_pkg::PARITY_MASK;
    if (ch >= rcso_pkg::CHR_LC_A && ch <= rcso_pkg::CHR_LC_Z) begin
      ch = ch & ~rcso_pkg::CASE_BIT;
    end
    is_digit = ch >= rcso_pkg::CHR_ZERO && ch <= rcso_pkg::CHR_DIG_9;
    is_sign = ch == rcso_pkg::CHR_PLUS || ch == rcso_pkg::CHR_MINUS;
    is_term = ch == rcso_pkg::CHR_LF || ch == rcso_pkg::CHR_SEMI ||
              ch == rcso_pkg::CHR_COMMA;
  end

  // Next-state of the character filter
  always_comb begin
    next_in_num = in_num;
    next_seen_nz = seen_nz;
    next_num_len = num_len;
    next_cmd_valid = 1'b0;
    next_cmd_char = cmd_char;
    next_cmd_is_term = 1'b0;
    next_cmd_fund = 1'b0;
    next_ovf = 1'b0;
    next_prev_alpha = prev_alpha;
    if (rx_valid) begin
      if (ch == rcso_pkg::CHR_SPACE || ch == rcso_pkg::CHR_CR) begin
        next_cmd_valid = 1'b0;
      end else if (is_sign && !(prev_alpha && ch == rcso_pkg::CHR_MINUS)
                   && (ch == rcso_pkg::CHR_PLUS || !in_num && !prev_alpha)) begin
        next_cmd_valid = 1'b0;
      end else if (ch == rcso_pkg::CHR_ZERO && !seen_nz) begin
        next_in_num = 1'b1;
      end else begin
        next_cmd_valid = 1'b1;
        next_cmd_char = ch;
        if (is_term) begin
          next_cmd_is_term = 1'b1;
          next_cmd_fund = in_num;
          next_in_num = 1'b0;
          next_seen_nz = 1'b0;
          next_num_len = '0;
        end else if (is_digit || is_sign || ch == rcso_pkg::CHR_DOT ||
                     (in_num && ch == rcso_pkg::CHR_E)) begin
          next_in_num = 1'b1;
          next_seen_nz = 1'b1;
          if (num_len == 5'(rcso_pkg::NUM_FIELD_MAX)) begin
            next_ovf = 1'b1;
            next_cmd_valid = 1'b0;
          end else begin
            next_num_len = num_len + 5'h01;
          end
        end else begin
          next_in_num = 1'b0;
          next_seen_nz = 1'b0;
          next_num_len = '0;
        end
      end
      next_prev_alpha = !is_digit && !is_sign && !is_term;
    end
  end

  // Character filter registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_num <= 1'b0;
      seen_nz <= 1'b0;
      num_len <= '0;
      cmd_valid <= 1'b0;
      cmd_char <= 8'h00;
      cmd_is_term <= 1'b0;
      cmd_fund_units <= 1'b0;
      field_overflow <= 1'b0;
      prev_alpha <= 1'b0;
    end else begin
      in_num <= next_in_num;
      seen_nz <= next_seen_nz;
      num_len <= next_num_len;
      cmd_valid <= next_cmd_valid;
      cmd_char <= next_cmd_char;
      cmd_is_term <= next_cmd_is_term;
      cmd_fund_units <= next_cmd_fund;
      field_overflow <= next_ovf;
      prev_alpha <= next_prev_alpha;
    end
  end

  // Alternate sweep clamp of the first sweep
  always_comb begin
    first_sweep_time_ms = sweep_time_ms;
    if (alt_sweep_two_power &&
        sweep_time_ms < 16'(rcso_pkg::MIN_ALT_SWEEP_MS)) begin
      first_sweep_time_ms = 16'(rcso_pkg::MIN_ALT_SWEEP_MS);
    end
  end

  // Status bytes and preset settings; stored states, address, mask
  // live elsewhere and are untouched here
  logic [7:0] next_s1, next_s2, next_s3;
  logic status_clear;
  always_comb begin
    status_clear = serial_poll || device_clear || clear_status_cmd ||
                   preset_cmd;
    next_s1 = (status_clear ? 8'h00 : status1) | status_set1;
    next_s2 = (status_clear ? 8'h00 : status2) | status_set2;
    next_s3 = (status_clear ? 8'h00 : status3) | status_set3;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status1 <= 8'h00;
      status2 <= 8'h00;
      status3 <= 8'h00;
      preset_pulse <= 1'b0;
      blanking_on <= 1'b1;
      rf_filter_on <= 1'b1;
      step_pct <= rcso_pkg::STEP_PCT;
      pwr_step_db <= rcso_pkg::PWR_STEP_DB;
      slope_db <= 8'h00;
      xtal_mhz <= rcso_pkg::XTAL_MHZ;
      xtal_on <= 1'b0;
      marker_on <= 5'h00;
      disp_mult <= rcso_pkg::DISP_MULT_ONE;
      disp_offset <= 16'h0000;
      vernier <= 16'h0000;
    end else begin
      status1 <= next_s1;
      status2 <= next_s2;
      status3 <= next_s3;
      preset_pulse <= preset_cmd;
      if (preset_cmd) begin
        marker_on <= 5'h00;
        blanking_on <= 1'b1;
        step_pct <= rcso_pkg::STEP_PCT;
        pwr_step_db <= rcso_pkg::PWR_STEP_DB;
        slope_db <= 8'h00;
        rf_filter_on <= 1'b1;
        xtal_mhz <= rcso_pkg::XTAL_MHZ;
        xtal_on <= 1'b0;
        disp_mult <= rcso_pkg::DISP_MULT_ONE;
        disp_offset <= 16'h0000;
        vernier <= 16'h0000;
      end
    end
  end

  // Output message serialiser
  rcso_pkg::rcso_state_e st, next_st;
  rcso_pkg::rcso_msg_e kind, next_kind;
  logic [6:0] idx, next_idx, last, next_last;
  logic [7:0] byte_sel;
  logic f_in_ready, f_out_valid;
  logic [8:0] f_out_data;
  logic req;
  logic active_sel, next_active_sel;
  logic [NUM_BITS-1:0] num_text;

  // Numeric reply source: queried function or the active one
  assign num_text = active_sel ? active_text : value_text;

  // Pick byte idx of the held message
  always_comb begin
    byte_sel = 8'h00;
    unique case (kind)
      rcso_pkg::RCSO_MSG_FULL: byte_sel = state_image[idx*8 +: 8];
      rcso_pkg::RCSO_MSG_QCW: byte_sel = quick_cw_image[idx[2:0]*8 +: 8];
      rcso_pkg::RCSO_MSG_MODE: byte_sel = mode_flags_image[idx[2:0]*8 +: 8];
      rcso_pkg::RCSO_MSG_NUM: begin
        if (idx == 7'(rcso_pkg::NUM_REPLY_LEN)) begin
          byte_sel = rcso_pkg::CHR_LF;
        end else begin
          byte_sel = num_text[(rcso_pkg::NUM_REPLY_LEN - 1 - idx[3:0]) * 8
                              +: 8];
        end
      end
      rcso_pkg::RCSO_MSG_STAT: begin
        byte_sel = idx == 7'h00 ? status1 :
                   idx == 7'h01 ? status2 : status3;
      end
      default: byte_sel = 8'h00;
    endcase
  end

  always_comb begin
    req = full_state_dump_cmd || quick_cw_dump_cmd || mode_flags_dump_cmd ||
          value_query_cmd || active_value_query_cmd || status_read_cmd;
    next_st = st;
    next_kind = kind;
    next_idx = idx;
    next_last = last;
    unique case (st)
      rcso_pkg::RCSO_IDLE: begin
        if (req) begin
          next_st = rcso_pkg::RCSO_LOAD;
          next_idx = 7'h00;
          if (full_state_dump_cmd) begin
            next_kind = rcso_pkg::RCSO_MSG_FULL;
            next_last = 7'(rcso_pkg::FULL_DUMP_LEN - 1);
          end else if (quick_cw_dump_cmd) begin
            next_kind = rcso_pkg::RCSO_MSG_QCW;
            next_last = 7'(rcso_pkg::QUICK_CW_LEN - 1);
          end else if (mode_flags_dump_cmd) begin
            next_kind = rcso_pkg::RCSO_MSG_MODE;
            next_last = 7'(rcso_pkg::MODE_FLAGS_LEN - 1);
          end else if (status_read_cmd) begin
            next_kind = rcso_pkg::RCSO_MSG_STAT;
            next_last = 7'(rcso_pkg::STATUS_LEN - 1);
          end else begin
            next_kind = rcso_pkg::RCSO_MSG_NUM;
            next_last = 7'(rcso_pkg::NUM_REPLY_LEN);
          end
        end
      end
      rcso_pkg::RCSO_LOAD: begin
        if (talk_addressed) begin
          next_st = rcso_pkg::RCSO_SEND;
        end
      end
      rcso_pkg::RCSO_SEND: begin
        if (f_in_ready) begin
          next_idx = idx + 7'h01;
          if (idx == last) begin
            next_st = rcso_pkg::RCSO_IDLE;
          end
        end
      end
      default: next_st = rcso_pkg::RCSO_IDLE;
    endcase
  end

  always_comb begin
    next_active_sel = active_sel;
    if (st == rcso_pkg::RCSO_IDLE && req) begin
      next_active_sel = active_value_query_cmd && !value_query_cmd;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= rcso_pkg::RCSO_IDLE;
      kind <= rcso_pkg::RCSO_MSG_FULL;
      idx <= 7'h00;
      last <= 7'h00;
      active_sel <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      idx <= next_idx;
      last <= next_last;
      active_sel <= next_active_sel;
    end
  end

  // Byte plus end flag into the FIFO; EOI rides with last byte
  rcso_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(st == rcso_pkg::RCSO_SEND),
    .in_ready(f_in_ready),
    .in_data({idx == last, byte_sel}),
    .out_valid(f_out_valid),
    .out_ready(tx_ready && talk_addressed),
    .out_data(f_out_data)
  );

  // Talker outputs, gated until addressed
  always_comb begin
    tx_valid = f_out_valid && talk_addressed;
    tx_data = f_out_data[7:0];
    tx_eoi = f_out_data[8];
    busy = st != rcso_pkg::RCSO_IDLE || f_out_valid;
  end
endmodule // rcso_top
`default_nettype wire

// file: rcso_top_asserts.sv
// Concurrent checks on the command, preset, status and talker ports.
// Assumes a bind onto rcso_top; one clock, async active-low reset.
`default_nettype none
module rcso_top_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_char,
  input wire logic preset_cmd,
  input wire logic preset_pulse,
  input wire logic blanking_on,
  input wire logic [15:0] step_pct,
  input wire logic [7:0] disp_mult,
  input wire logic [4:0] marker_on,
  input wire logic alt_sweep_two_power,
  input wire logic [15:0] sweep_time_ms,
  input wire logic [15:0] first_sweep_time_ms,
  input wire logic serial_poll,
  input wire logic [7:0] status_set1,
  input wire logic [7:0] status1,
  input wire logic talk_addressed,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_eoi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] rx7;
  logic [15:0] clamp;
  // Received byte without parity, and the clamped sweep time
  assign rx7 = rx_data & 8'h7F;
  assign clamp = (sweep_time_ms < 16'h03E8) ? 16'h03E8 : sweep_time_ms;
  property p_fold;
    rx_valid && rx7 >= 8'h61 && rx7 <= 8'h7A
      |=> cmd_valid && cmd_char == $past(rx7) - 8'h20;
  endproperty
  a_fold: assert property (p_fold) else $error("case fold");
  property p_drop;
    rx_valid && (rx7 == 8'h20 || rx7 == 8'h0D || rx7 == 8'h2B) |=> !cmd_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("no drop");
  property p_par;
    cmd_valid |-> !cmd_char[7];
  endproperty
  a_par: assert property (p_par) else $error("parity kept");
  property p_clamp;
    first_sweep_time_ms == (alt_sweep_two_power ? clamp : sweep_time_ms);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
  property p_preset;
    preset_cmd |=> preset_pulse ##[0:1] (blanking_on && step_pct == 16'h000A
      && disp_mult == 8'h01 && marker_on == 5'h00);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eoi);
  endproperty
  a_hold: assert property (p_hold)
    else $error("tx not held");
  property p_talk;
    !talk_addressed |-> !tx_valid;
  endproperty
  a_talk: assert property (p_talk)
    else $error("sent unaddressed");
  property p_stclr;
    serial_poll && status_set1 == 8'h00 |=> status1 == 8'h00;
  endproperty
  a_stclr: assert property (p_stclr) else $error("poll clear");
  property p_stset;
    status_set1 != 8'h00 |=> (status1 & $past(status_set1)) == $past(status_set1);
  endproperty
  a_stset: assert property (p_stset) else $error("status set");
  // Main scenarios reached
  c_last: cover property (tx_valid && tx_ready && tx_eoi);
  c_preset: cover property (preset_pulse);
  c_poll: cover property (serial_poll);
endmodule // rcso_top_asserts
`default_nettype wire

// file: tb_remote_command_and_state_output.sv
// Self-checking bench for rcso_top with a controller model on the talker.
// Assumes rcso_pkg, rcso_fifo, rcso_top and the checker are compiled first.
`default_nettype none
module tb_remote_command_and_state_output;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, rx_valid = 0, talk_en = 0, slow = 0, alt = 0;
  logic cmd_valid, is_term, fund, ovf, tx_valid, tx_ready, tx_eoi, talk;
  logic blank, filt, xon, pp, busy;
  logic [7:0] rx_data = 0, cmd_char, tx_data, pw, sl, xm, dm;
  logic [7:0] st[3], ss[3] = '{0, 0, 0}, exp_st[3];
  logic [5:0] cmd = 0;
  logic [3:0] clr = 0;
  logic [4:0] mk;
  logic [15:0] swt = 0, fst, stp, dof, ver;
  logic [719:0] img = 0;
  logic [63:0] qcw = 0, mfl = 0;
  logic [111:0] txt = 0, atx = 0;
  int fails = 0, checked = 0, cyc = 0, novf = 0;
  always #4 clk = ~clk;
  rcso_top #(.FIFO_DEPTH(8), .STATE_BYTES(90)) uut (.clk(clk), .rstn(rstn),
    .rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid),
    .cmd_char(cmd_char), .cmd_is_term(is_term), .cmd_fund_units(fund),
    .field_overflow(ovf), .full_state_dump_cmd(cmd[0]),
    .quick_cw_dump_cmd(cmd[1]), .mode_flags_dump_cmd(cmd[2]),
    .value_query_cmd(cmd[3]), .active_value_query_cmd(cmd[4]),
    .status_read_cmd(cmd[5]), .preset_cmd(clr[3]),
    .clear_status_cmd(clr[2]), .serial_poll(clr[0]), .device_clear(clr[1]),
    .state_image(img), .quick_cw_image(qcw), .mode_flags_image(mfl),
    .value_text(txt), .active_text(atx), .status_set1(ss[0]),
    .status_set2(ss[1]), .status_set3(ss[2]), .alt_sweep_two_power(alt),
    .sweep_time_ms(swt), .first_sweep_time_ms(fst), .status1(st[0]),
    .status2(st[1]), .status3(st[2]), .preset_pulse(pp), .blanking_on(blank),
    .rf_filter_on(filt), .step_pct(stp), .pwr_step_db(pw), .slope_db(sl),
    .xtal_mhz(xm), .xtal_on(xon), .marker_on(mk), .disp_mult(dm),
    .disp_offset(dof), .vernier(ver), .talk_addressed(talk),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_eoi(tx_eoi), .busy(busy));
  rcso_ctrl_model ctl (.clk(clk), .talk_en(talk_en), .slow(slow),
    .talk_addressed(talk), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_eoi(tx_eoi));
  // Cycle limit and overflow pulse count
  always @(posedge clk) begin
    cyc++;
    if (ovf === 1'b1) novf++;
    if (cyc == 30000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Expected normalised character, bit 8 set when it is kept
  function automatic logic [8:0] norm(input logic [7:0] c);
    logic [7:0] c7;
    c7 = c & 8'h7F;
    if (c7 == 8'h20 || c7 == 8'h0D || c7 == 8'h2B) return 9'h000;
    if (c7 >= 8'h61 && c7 <= 8'h7A) return {1'b1, c7 - 8'h20};
    return {1'b1, c7};
  endfunction
  task automatic send(input logic [7:0] c);
    rx_data = c;
    rx_valid = 1'b1;
    tick();
    chk(cmd_valid, norm(c) >> 8);
    if (norm(c) >> 8) chk(cmd_char, norm(c) & 9'h0FF);
  endtask
  // Digits beyond the fourteenth are refused, the terminator still counts
  task automatic field(input int n);
    for (int i = 0; i < n; i++) begin
      if (i < 14) send(8'h31);
      else begin
        rx_data = 8'h31;
        tick();
        chk(cmd_valid, 1'b0);
      end
    end
    send(8'h3B);
    chk({is_term, fund}, 2'b11);
    rx_valid = 1'b0;
    tick();
  endtask
  // Request one message and compare every byte and the EOI flag
  task automatic msg(input int k);
    logic [8:0] e[$];
    int n;
    n = (k == 0) ? 90 : (k == 5) ? 3 : 8;
    for (int i = 0; i < n && k != 3 && k != 4; i++) begin
      logic [7:0] b;
      b = (k == 0) ? img[i*8+:8] : (k == 1) ? qcw[i*8+:8] :
        (k == 2) ? mfl[i*8+:8] : exp_st[i];
      e.push_back({i == n - 1, b});
    end
    for (int i = 0; i < 14 && (k == 3 || k == 4); i++)
      e.push_back({1'b0, (k == 4) ? atx[111-8*i-:8] : txt[111-8*i-:8]});
    if (k == 3 || k == 4) e.push_back(9'h10A);
    cmd[k] = 1'b1;
    tick();
    cmd = 0;
    tick(10);
    chk(ctl.got.size(), 0);
    chk(busy, 1'b1);
    talk_en = 1'b1;
    tick(3);
    cmd[5] = (k == 0);
    tick();
    cmd = 0;
    for (int i = 0; i < 3000 && ctl.got.size() < e.size(); i++) tick();
    tick(20);
    chk(ctl.got.size(), e.size());
    chk(busy, 1'b0);
    for (int i = 0; i < e.size() && i < ctl.got.size(); i++)
      chk(ctl.got[i], e[i]);
    talk_en = 1'b0;
    ctl.got.delete();
    $display("message kind %0d done", k);
  endtask
  initial begin
    void'($urandom(55004));
    tick(6);
    rstn = 1'b1;
    tick();
    for (int i = 0; i < 40; i++) begin
      logic [7:0] t[4];
      // Case bit only on letters; parity bit on any character
      t = '{8'h20, 8'h0D, 8'h2B,
            8'((8'h41 + $urandom % 26) | ($urandom % 2 ? 8'h20 : 8'h00))};
      send(8'(t[$urandom % 4] | ($urandom % 2 ? 8'h80 : 8'h00)));
    end
    rx_valid = 1'b0;
    tick();
    field(14);
    chk(novf, 0);
    field(15);
    chk(novf, 1);
    $display("receive test done");
    for (int i = 0; i < 90; i++) img[i*8+:8] = (i % 9) ? $urandom : 8'h0A;
    qcw = {$urandom, $urandom};
    mfl = {$urandom, $urandom};
    for (int i = 0; i < 14; i++) begin
      txt[i*8+:8] = 8'h30 + $urandom % 10;
      atx[i*8+:8] = 8'h30 + $urandom % 10;
    end
    ss = '{$urandom, $urandom, $urandom};
    exp_st = ss;
    tick();
    ss = '{0, 0, 0};
    for (int k = 0; k < 6; k++) begin
      slow = (k == 0 || k == 3);
      msg(k);
    end
    for (int c = 0; c < 4; c++) begin
      ss = '{8'h41, 8'h20, 8'h01};
      tick();
      ss = '{0, 0, 0};
      clr[c] = 1'b1;
      tick();
      clr = 0;
      tick(2);
      for (int j = 0; j < 3; j++) chk(st[j], 8'h00);
    end
    chk({blank, filt, xon, mk}, 8'hC0);
    chk(stp, 16'h000A);
    chk({pw, sl}, 16'h0100);
    chk({xm, dm}, 16'h3201);
    chk(dof | ver, 16'h0000);
    $display("preset and status test done");
    for (int i = 0; i < 24; i++) begin
      alt = $urandom % 2;
      swt = (i < 3) ? 16'h03E7 + i : $urandom % 3000;
      tick();
      chk(fst, (alt && swt < 16'h03E8) ? 16'h03E8 : swt);
    end
    $display("sweep clamp test done");
    final_report();
  end
endmodule // tb_remote_command_and_state_output
bind rcso_top rcso_top_asserts u_chk (.clk(clk), .rstn(rstn),
  .rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid),
  .cmd_char(cmd_char), .preset_cmd(preset_cmd), .preset_pulse(preset_pulse),
  .blanking_on(blanking_on), .step_pct(step_pct), .disp_mult(disp_mult),
  .marker_on(marker_on), .alt_sweep_two_power(alt_sweep_two_power),
  .sweep_time_ms(sweep_time_ms), .first_sweep_time_ms(first_sweep_time_ms),
  .serial_poll(serial_poll), .status_set1(status_set1), .status1(status1),
  .talk_addressed(talk_addressed), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .tx_eoi(tx_eoi));
`default_nettype wire
